// ===== rtl/rtcisp_top.sv
// rtc serial slave port: two-wire bus front end and register access side
module rtcisp_top
    import rtcisp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              scl,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_n,
    output logic                   busy,
    output logic                   wr_valid,
    input  wire logic              wr_ready,
    output logic [BYTE_W-1:0]      wr_addr,
    output logic [BYTE_W-1:0]      wr_data,
    output logic                   wr_drop,
    output logic                   rd_req,
    output logic [BYTE_W-1:0]      rd_addr,
    input  wire logic              rd_valid,
    input  wire logic [BYTE_W-1:0] rd_data
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic              scl_f;
    logic              sda_f;
    logic              next_scl_f;
    logic              next_sda_f;
    logic              start_det;
    logic              stop_det;
    logic              link_clr;
    logic [CNT_W-1:0]  clr_cnt;

    rtcisp_state_t     state;
    logic [CNT_W-1:0]  bitcnt;
    logic [BYTE_W-1:0] rx_sh;
    logic [BYTE_W-1:0] rx_full;
    logic [BYTE_W-1:0] rx_hold;
    rtcisp_kind_t      rx_kind;
    logic              rx_tgl;
    logic              ack_own;
    logic              ack_fifo;
    logic [BYTE_W-1:0] tx_sh;
    logic              ld_tgl;

    logic [2:0]        rx_s;
    logic [2:0]        ld_s;
    logic              rx_evt;
    logic              ld_evt;
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] tx_byte;
    logic              ack_ok;
    logic              rd_pend;
    logic              fetch_go;
    logic [BYTE_W-1:0] fetch_addr;

    logic              hold_v;
    logic [BYTE_W-1:0] hold_addr;
    logic [BYTE_W-1:0] hold_data;
    logic              fifo_full;
    logic              push;
    logic              pop;

    // ------------------------------------------------------------
    // pin sampling on mclk
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_s <= SYNC_IDLE;
            sda_s <= SYNC_IDLE;
        end else begin
            scl_s <= {scl_s[1:0], scl};
            sda_s <= {sda_s[1:0], sda_in};
        end
    end

    // a change counts only once second and third stage agree
    always_comb begin
        next_scl_f = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f;
        next_sda_f = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            scl_f <= 1'b1;
            sda_f <= 1'b1;
        end else begin
            scl_f <= next_scl_f;
            sda_f <= next_sda_f;
        end
    end

    // ------------------------------------------------------------
    // start and stop detection
    // ------------------------------------------------------------
    assign start_det = scl_f & next_scl_f & sda_f & ~next_sda_f;
    assign stop_det  = scl_f & next_scl_f & ~sda_f & next_sda_f;

    always_ff @(posedge mclk) begin
        if (rst) begin
            busy <= 1'b0;
        end else if (start_det) begin
            busy <= 1'b1;
        end else if (stop_det) begin
            busy <= 1'b0;
        end
    end

    // short clear pulse into the scl domain; the master keeps scl high
    // for far longer than this after a start, so the release never
    // meets an scl edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            link_clr <= 1'b1;
            clr_cnt  <= CLR_CYC;
        end else if (start_det || stop_det) begin
            link_clr <= 1'b1;
            clr_cnt  <= CLR_CYC;
        end else if (clr_cnt != CLR_DONE) begin
            clr_cnt  <= clr_cnt - CNT_STEP;
        end else begin
            link_clr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // link side, rising scl: sample bits and decode bytes
    // ------------------------------------------------------------
    assign rx_full = {rx_sh[BYTE_W-2:0], sda_in};

    always_ff @(posedge scl or posedge link_clr) begin
        if (link_clr) begin
            state    <= LS_ADDR;
            bitcnt   <= BIT_FIRST;
            rx_sh    <= BYTE_RST;
            rx_hold  <= BYTE_RST;
            rx_kind  <= RK_PTR;
            rx_tgl   <= 1'b0;
            ack_own  <= 1'b0;
            ack_fifo <= 1'b0;
        end else if (bitcnt == BIT_ACK) begin
            bitcnt <= BIT_FIRST;
            if (state == LS_RDATA && sda_in) begin
                state <= LS_IGNORE;
            end
        end else begin
            rx_sh  <= rx_full;
            bitcnt <= bitcnt + CNT_STEP;
            if (bitcnt == BIT_LAST) begin
                ack_own  <= 1'b0;
                ack_fifo <= 1'b0;
                case (state)
                    LS_ADDR: begin
                        if (rx_full[BYTE_W-1:1] == SLAVE_ADDR) begin
                            ack_own <= 1'b1;
                            if (rx_full[0]) begin
                                state   <= LS_RDATA;
                                rx_kind <= RK_ADDR_RD;
                                rx_hold <= rx_full;
                                rx_tgl  <= ~rx_tgl;
                            end else begin
                                state <= LS_PTR;
                            end
                        end else begin
                            state <= LS_IGNORE;
                        end
                    end
                    LS_PTR: begin
                        ack_own <= 1'b1;
                        state   <= LS_WDATA;
                        rx_kind <= RK_PTR;
                        rx_hold <= rx_full;
                        rx_tgl  <= ~rx_tgl;
                    end
                    LS_WDATA: begin
                        ack_fifo <= 1'b1;
                        rx_kind  <= RK_WDATA;
                        rx_hold  <= rx_full;
                        rx_tgl   <= ~rx_tgl;
                    end
                    default: begin
                        ack_own <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // link side, falling scl: drive sda (open drain, scl untouched)
    // ------------------------------------------------------------
    // ack_ok and tx_byte are mclk words read here; both settle long
    // before the scl edge that reads them, since the core answers a
    // byte event in a few mclk cycles and the bus gives a clock phase
    always_ff @(negedge scl or posedge link_clr) begin
        if (link_clr) begin
            sda_oe_n <= 1'b1;
            tx_sh    <= BYTE_RST;
            ld_tgl   <= 1'b0;
        end else begin
            case (bitcnt)
                BIT_ACK: begin
                    sda_oe_n <= ~(ack_own | (ack_fifo & ack_ok));
                end
                BIT_FIRST: begin
                    if (state == LS_RDATA) begin
                        sda_oe_n <= tx_byte[BYTE_W-1];
                        tx_sh    <= {tx_byte[BYTE_W-2:0], 1'b0};
                        ld_tgl   <= ~ld_tgl;
                    end else begin
                        sda_oe_n <= 1'b1;
                    end
                end
                default: begin
                    if (state == LS_RDATA) begin
                        sda_oe_n <= tx_sh[BYTE_W-1];
                        tx_sh    <= {tx_sh[BYTE_W-2:0], 1'b0};
                    end else begin
                        sda_oe_n <= 1'b1;
                    end
                end
            endcase
        end
    end

    // the port only ever pulls low; scl has no driver at all
    always_ff @(posedge mclk) begin
        sda_out <= 1'b0;
    end

    // ------------------------------------------------------------
    // byte events into mclk
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_s <= TGL_RST;
            ld_s <= TGL_RST;
        end else begin
            rx_s <= {rx_s[1:0], rx_tgl};
            ld_s <= {ld_s[1:0], ld_tgl};
        end
    end

    // toggles jump back to zero on a link clear; swallow that
    assign rx_evt = (rx_s[1] ^ rx_s[2]) & ~link_clr;
    assign ld_evt = (ld_s[1] ^ ld_s[2]) & ~link_clr;

    // ------------------------------------------------------------
    // register pointer and read fetch
    // ------------------------------------------------------------
    assign push = rx_evt && (rx_kind == RK_WDATA) && !fifo_full;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ptr <= PTR_RST;
        end else if (rx_evt && rx_kind == RK_PTR) begin
            ptr <= rx_hold;
        end else if (push || ld_evt) begin
            ptr <= ptr + PTR_STEP;
        end
    end

    // fetch the next byte as soon as one is loaded, so a whole byte
    // time is left for the register side to answer
    always_comb begin
        fetch_go   = (rx_evt && rx_kind == RK_ADDR_RD) || ld_evt;
        fetch_addr = ld_evt ? ptr + PTR_STEP : ptr;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rd_req  <= 1'b0;
            rd_addr <= PTR_RST;
            rd_pend <= 1'b0;
            tx_byte <= BYTE_RST;
        end else begin
            rd_req <= fetch_go;
            if (fetch_go) begin
                rd_addr <= fetch_addr;
                rd_pend <= 1'b1;
            end else if (rd_valid && rd_pend) begin
                rd_pend <= 1'b0;
                tx_byte <= rd_data;
            end
        end
    end

    // ------------------------------------------------------------
    // write buffer: two entries, head drives the outputs
    // ------------------------------------------------------------
    // no clock stretching is allowed, so a full buffer turns into a
    // nack of the data byte instead of a stall on the bus
    assign fifo_full = wr_valid & hold_v;
    assign pop       = wr_valid & wr_ready;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ack_ok  <= 1'b0;
            wr_drop <= 1'b0;
        end else begin
            wr_drop <= rx_evt && (rx_kind == RK_WDATA) && fifo_full;
            if (rx_evt && rx_kind == RK_WDATA) begin
                ack_ok <= ~fifo_full;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_valid  <= 1'b0;
            wr_addr   <= PTR_RST;
            wr_data   <= BYTE_RST;
            hold_v    <= 1'b0;
            hold_addr <= PTR_RST;
            hold_data <= BYTE_RST;
        end else if (!wr_valid || (pop && !hold_v)) begin
            wr_valid <= push;
            if (push) begin
                wr_addr <= ptr;
                wr_data <= rx_hold;
            end
        end else if (pop) begin
            wr_addr <= hold_addr;
            wr_data <= hold_data;
            hold_v  <= push;
            if (push) begin
                hold_addr <= ptr;
                hold_data <= rx_hold;
            end
        end else if (push) begin
            hold_v    <= 1'b1;
            hold_addr <= ptr;
            hold_data <= rx_hold;
        end
    end

endmodule

// ===== rtl/rtcisp_pkg.sv
// constants and types of the rtc serial slave port
package rtcisp_pkg;

    // ------------------------------------------------------------
    // bus address and byte framing
    // ------------------------------------------------------------
    localparam logic [6:0] SLAVE_ADDR = 7'h68;
    localparam int         BYTE_W     = 8;
    localparam int         CNT_W      = 4;
    localparam logic [3:0] BIT_FIRST  = 4'h0;
    localparam logic [3:0] BIT_LAST   = 4'h7;
    localparam logic [3:0] BIT_ACK    = 4'h8;
    localparam logic [3:0] CNT_STEP   = 4'h1;

    // ------------------------------------------------------------
    // reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_RST    = 8'h00;
    localparam logic [7:0] PTR_STEP   = 8'h01;
    localparam logic [7:0] BYTE_RST   = 8'h00;
    localparam logic [2:0] SYNC_IDLE  = 3'h7;
    localparam logic [2:0] TGL_RST    = 3'h0;
    localparam logic [3:0] CLR_CYC    = 4'h4;
    localparam logic [3:0] CLR_DONE   = 4'h0;

    // ------------------------------------------------------------
    // link state and byte kinds handed to the core
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        LS_ADDR,
        LS_PTR,
        LS_WDATA,
        LS_RDATA,
        LS_IGNORE
    } rtcisp_state_t;

    typedef enum logic [1:0] {
        RK_ADDR_RD,
        RK_PTR,
        RK_WDATA
    } rtcisp_kind_t;

endpackage

// ===== tb/rtcisp_top_chk.sv
// port checker for the rtc serial slave port
module rtcisp_top_chk
    import rtcisp_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst,
    input wire logic       scl,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       busy,
    input wire logic       wr_valid,
    input wire logic       wr_ready,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic       wr_drop,
    input wire logic       rd_req,
    input wire logic [7:0] rd_addr,
    input wire logic       rd_valid,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // relations on mclk
    // ----
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // scl high phase is 15 mclk, so 8 is a safe floor
    sequence s_scl_up;
        $rose(scl) ##0 !sda_oe_n;
    endsequence
    sequence s_low_held;
        !sda_oe_n [*8];
    endsequence
    chk_ack_held: assert property (s_scl_up |=> s_low_held)
        else $error("sda released during clock high");
    chk_out_low: assert property (sda_out == 1'b0)
        else $error("sda drive level not low");
    chk_drive_clk: assert property ($fell(sda_oe_n) |-> !scl)
        else $error("sda pulled while clock high");
    chk_idle_free: assert property (!busy |-> sda_oe_n)
        else $error("sda driven outside a transfer");
    chk_wr_hold: assert property (wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_addr) && $stable(wr_data))
        else $error("stalled write word changed");
    chk_rd_pulse: assert property (rd_req |=> !rd_req)
        else $error("read request longer than one cycle");
    chk_rd_addr: assert property ($changed(rd_addr) |-> rd_req)
        else $error("read address moved without request");
    chk_drop_full: assert property (wr_drop |-> $past(wr_valid) ##1 !wr_drop)
        else $error("drop pulse without full buffer");
    chk_wr_busy: assert property ($rose(wr_valid) |-> busy)
        else $error("write word outside a transfer");
    chk_rd_busy: assert property (rd_req |-> busy)
        else $error("read request outside a transfer");
endmodule
bind rtcisp_top rtcisp_top_chk u_chk (
    .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_drop(wr_drop), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data)
);

// ===== tb/rtcisp_master.sv
// two-wire bus master model
module rtcisp_master (
    input  wire logic lclk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // bus phases
    // ----
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // long phases: start and stop detect needs scl high over 80 ns
    task automatic ph();
        repeat (8) @(posedge lclk);
    endtask
    // hold after scl fall so data never moves with the clock high
    task automatic frame(input logic a, input logic b);
        repeat (2) @(posedge lclk);
        sda_m = a;
        ph();
        scl = 1'b1;
        ph();
        sda_m = b;
        ph();
    endtask
    task automatic start();
        frame(1'b1, 1'b0);
        scl = 1'b0;
    endtask
    task automatic stop();
        frame(1'b0, 1'b1);
    endtask
    task automatic bit_x(input logic b, output logic s);
        repeat (2) @(posedge lclk);
        sda_m = b;
        ph();
        scl = 1'b1;
        ph();
        s = sda;
        scl = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(b[i], s);
        end
        bit_x(1'b1, s);
        ack = ~s;
    endtask
    task automatic rbyte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, s);
            b[i] = s;
        end
        bit_x(last, s);
    endtask
endmodule

// ===== tb/rtc_i2c_slave_port_tb_top.sv
// self-checking bench for the rtc serial slave port
`define CHK(g, e) \
    begin \
        checks++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("FAIL %0t got %h exp %h", $time, (g), (e)); \
        end \
    end
module rtc_i2c_slave_port_tb_top
    import rtcisp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        lclk = 1'b0;
    logic        rst, wr_ready, rd_valid, stall, scl, sda_m, sda_out, sda_oe_n;
    logic        busy, wr_valid, wr_drop, rd_req, ack;
    logic [7:0]  rd_data, rd_addr, wr_addr, wr_data, p, ra, d, rb, rr;
    logic [15:0] gv, ev;
    logic [15:0] got[$];
    logic [15:0] exp[$];
    integer      seed, fail_count, checks, drops, k, n, m;
    // pull-up: a released wire reads high
    wire         sda = sda_m & (sda_oe_n | sda_out);
    always #4 mclk = ~mclk;
    always #7.5 lclk = ~lclk;
    // ----
    // helpers and far-side responders
    // ----
    function automatic logic [7:0] rnd8();
        logic [31:0] r;
        r = $random(seed);
        return r[7:0];
    endfunction
    function automatic logic [7:0] reg_val(input logic [7:0] a);
        return a ^ 8'h5a;
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    rtcisp_top dut (
        .mclk(mclk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .busy(busy), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_drop(wr_drop), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data)
    );
    rtcisp_master u_m (.lclk(lclk), .sda(sda), .scl(scl), .sda_m(sda_m));
    always begin
        @(posedge mclk);
        #1;
        rr = rnd8();
        wr_ready = ~stall & rr[0];
        if (wr_valid === 1'b1 && wr_ready) got.push_back({wr_addr, wr_data});
        if (wr_drop === 1'b1) drops++;
    end
    // answers after a random wait; the bus shows junk when idle
    always begin
        @(posedge mclk);
        #1;
        if (rd_req === 1'b1) begin
            ra = rd_addr;
            repeat (1 + rnd8() % 5) @(posedge mclk);
            #1;
            rd_valid = 1'b1;
            rd_data = reg_val(ra);
            @(posedge mclk);
            #1;
            rd_valid = 1'b0;
            rd_data = ~reg_val(ra);
        end
    end
    initial begin
        #400000;
        fail_count++;
        wrap_up();
    end
    // ----
    // tests
    // ----
    initial begin
        seed = 92;
        fail_count = 0;
        checks = 0;
        drops = 0;
        {rst, stall, wr_ready, rd_valid, rd_data} = {4'h8, 8'h00};
        repeat (5) @(posedge mclk);
        #1;
        rst = 1'b0;
        repeat (12) @(posedge mclk);
        // last pass stalls the consumer so the third byte is refused
        for (k = 0; k < 4; k++) begin
            stall = (k == 3);
            p = rnd8();
            n = stall ? 3 : 1 + rnd8() % 3;
            u_m.start();
            `CHK(busy, 1'b1)
            u_m.wbyte(8'hd0, ack);
            `CHK(ack, 1'b1)
            u_m.wbyte(p, ack);
            `CHK(ack, 1'b1)
            for (int i = 0; i < n; i++) begin
                d = rnd8();
                u_m.wbyte(d, ack);
                `CHK(ack, !stall || i < 2)
                if (!stall || i < 2) exp.push_back({p + 8'(i), d});
            end
            m = exp.size();
            u_m.stop();
            repeat (60) @(posedge mclk);
            stall = 1'b0;
            repeat (60) @(posedge mclk);
            `CHK(busy, 1'b0)
            `CHK(drops, 32'(k == 3))
            `CHK(got.size(), m)
            while (exp.size() > 0) begin
                ev = exp.pop_front();
                gv = (got.size() > 0) ? got.pop_front() : 16'hxxxx;
                `CHK(gv, ev)
            end
            u_m.start();
            u_m.wbyte(8'hd1, ack);
            `CHK(ack, 1'b1)
            u_m.rbyte(1'b1, rb);
            `CHK(rb, reg_val(p + 8'(m)))
            u_m.stop();
            $display("write test %0d done", k);
        end
        p = rnd8();
        u_m.start();
        u_m.wbyte(8'hd0, ack);
        u_m.wbyte(p, ack);
        u_m.start();
        u_m.wbyte(8'hd1, ack);
        `CHK(ack, 1'b1)
        for (int i = 0; i < 3; i++) begin
            u_m.rbyte(i == 2, rb);
            `CHK(rb, reg_val(p + 8'(i)))
        end
        u_m.stop();
        $display("read test done");
        for (int j = 0; j < 2; j++) begin
            u_m.start();
            u_m.wbyte(j == 0 ? 8'hd2 : 8'h50, ack);
            `CHK(ack, 1'b0)
            u_m.wbyte(8'h00, ack);
            `CHK(ack, 1'b0)
            u_m.stop();
        end
        repeat (60) @(posedge mclk);
        `CHK(got.size(), 0)
        $display("foreign address test done");
        wrap_up();
    end
endmodule
